// ---- design/bst_map.svh ----
// boundary scan tap: codes, widths and fixed values
// assumes inclusion by bst_pkg and bst_tap only
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

`define BST_IR_LEN        6
`define BST_ID_LEN        32
`define BST_BSR_LEN       161
`define BST_IR_CAPTURE    6'h01
`define BST_ID_LSB        1'h1

`define BST_CODE_EXTEST   6'h00
`define BST_CODE_SAMPLE   6'h01
`define BST_CODE_CLAMP    6'h02
`define BST_CODE_HIGHZ    6'h05
`define BST_CODE_IDCODE   6'h24
`define BST_CODE_USERCODE 6'h25
`define BST_CODE_BYPASS   6'h3f

`endif

// ---- design/bst_pkg.sv ----
// boundary scan tap: shared types and instruction decode
// assumes bst_map.svh on the include path
package bst_pkg;
`include "bst_map.svh"

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } bst_jtag_in_t;

   typedef enum logic [15:0] {
      st_tlr     = 16'h0001,
      st_rti     = 16'h0002,
      st_sel_dr  = 16'h0004,
      st_cap_dr  = 16'h0008,
      st_sh_dr   = 16'h0010,
      st_ex1_dr  = 16'h0020,
      st_pa_dr   = 16'h0040,
      st_ex2_dr  = 16'h0080,
      st_upd_dr  = 16'h0100,
      st_sel_ir  = 16'h0200,
      st_cap_ir  = 16'h0400,
      st_sh_ir   = 16'h0800,
      st_ex1_ir  = 16'h1000,
      st_pa_ir   = 16'h2000,
      st_ex2_ir  = 16'h4000,
      st_upd_ir  = 16'h8000
   } bst_state_t;

   typedef enum logic [2:0] {
      in_extest, in_sample, in_idcode, in_usercode, in_clamp, in_highz, in_bypass
   } bst_instr_t;

   function automatic bst_instr_t bst_decode(input logic [5:0] code);
      bst_instr_t r;
      case (code)
         `BST_CODE_EXTEST:   r = in_extest;
         `BST_CODE_SAMPLE:   r = in_sample;
         `BST_CODE_IDCODE:   r = in_idcode;
         `BST_CODE_USERCODE: r = in_usercode;
         `BST_CODE_CLAMP:    r = in_clamp;
         `BST_CODE_HIGHZ:    r = in_highz;
         default:            r = in_bypass;
      endcase
      return r;
   endfunction

   function automatic bst_state_t bst_next(input bst_state_t s, input logic tms);
      bst_state_t n;
      case (s)
         st_tlr:    n = tms ? st_tlr    : st_rti;
         st_rti:    n = tms ? st_sel_dr : st_rti;
         st_sel_dr: n = tms ? st_sel_ir : st_cap_dr;
         st_cap_dr: n = tms ? st_ex1_dr : st_sh_dr;
         st_sh_dr:  n = tms ? st_ex1_dr : st_sh_dr;
         st_ex1_dr: n = tms ? st_upd_dr : st_pa_dr;
         st_pa_dr:  n = tms ? st_ex2_dr : st_pa_dr;
         st_ex2_dr: n = tms ? st_upd_dr : st_sh_dr;
         st_upd_dr: n = tms ? st_sel_dr : st_rti;
         st_sel_ir: n = tms ? st_tlr    : st_cap_ir;
         st_cap_ir: n = tms ? st_ex1_ir : st_sh_ir;
         st_sh_ir:  n = tms ? st_ex1_ir : st_sh_ir;
         st_ex1_ir: n = tms ? st_upd_ir : st_pa_ir;
         st_pa_ir:  n = tms ? st_ex2_ir : st_pa_ir;
         st_ex2_ir: n = tms ? st_upd_ir : st_sh_ir;
         st_upd_ir: n = tms ? st_sel_dr : st_rti;
         default:   n = st_tlr;
      endcase
      return n;
   endfunction
endpackage

// ---- design/bst_tap.sv ----
// boundary scan tap with instruction, bypass, identification and boundary registers
// assumes tck, tms, tdi, trst_n and pin inputs are asynchronous to clk; tck well below clk/4
//
// Summary of operation
// - tap has mode select, test clock, data in, data out and async low reset.
// - after tap reset the identification register sits between data in and out.
// - update loads shifted instruction, or identification code when nothing shifted.
// - unassigned instruction codes act as bypass.
// - code 111111 selects one-stage bypass register.
// - clamp drives pins from boundary cells, held, bypass as serial path.
// - extest selects 161-cell boundary register, pins driven from its cells.
// - sample/preload captures pins without disturbing operation, loads shifted cells.
// - highz floats all system outputs, bypass as serial path.
// - id word: version 31:28, family 27:12, maker 11:1.
// - usercode selects identification register with the same layout.
// - every pin observed, outputs drivable, bidirectional pins have three cells.
`timescale 1ns/100ps
`include "bst_map.svh"
module bst_tap import bst_pkg::*; #(
   parameter int          NI        = 40,
   parameter int          NO        = 40,
   parameter int          NB        = 27,
   parameter logic [3:0]  ID_VER    = 4'h1,    // arbitrary
   parameter logic [15:0] ID_PART   = 16'h0a5c, // arbitrary
   parameter logic [15:0] USER_PART = 16'h0a5d, // arbitrary
   parameter logic [10:0] ID_MAKER  = 11'h1aa  // arbitrary
) (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire bst_jtag_in_t  jtag,
   output      logic          tdo,
   output      logic          tdo_oe,
   input  wire logic [NI-1:0] in_pin,
   output      logic [NI-1:0] core_in,
   input  wire logic [NO-1:0] core_out,
   output      logic [NO-1:0] out_o,
   output      logic [NO-1:0] out_oe,
   input  wire logic [NB-1:0] core_bo,
   input  wire logic [NB-1:0] core_boe,
   output      logic [NB-1:0] core_bi,
   input  wire logic [NB-1:0] bidi_i,
   output      logic [NB-1:0] bidi_o,
   output      logic [NB-1:0] bidi_oe
);
   localparam int BSR = `BST_BSR_LEN;

   // -----------------------------------------------------------------
   // elaboration checks
   // -----------------------------------------------------------------
   if (NI + NO + 3 * NB != BSR) begin : g_bad_len
      $error("pin counts do not fill the boundary register");
   end
   if (NI < 1 || NO < 1 || NB < 1) begin : g_bad_cnt
      $error("each pin group needs at least one pin");
   end

   typedef struct packed {
      bst_jtag_in_t      j1;
      bst_jtag_in_t      j2;
      logic              tck_prev;
      logic [NI-1:0]     in1;
      logic [NI-1:0]     in2;
      logic [NB-1:0]     bi1;
      logic [NB-1:0]     bi2;
      bst_state_t        st;
      logic [5:0]        ir_sr;
      logic [5:0]        ir;
      logic              ir_new;
      logic              byp;
      logic [31:0]       id_sr;
      logic [BSR-1:0]    bsr_sr;
      logic [BSR-1:0]    bsr_up;
      logic              tdo;
      logic              tdo_oe;
      logic [NO-1:0]     out;
      logic [NO-1:0]     out_oe;
      logic [NB-1:0]     bo;
      logic [NB-1:0]     boe;
   } bst_reg_t;

   bst_reg_t       q;
   bst_reg_t       d;
   bst_instr_t     cur;
   logic           rise;
   logic           fall;
   logic           bsr_sel;
   logic           id_sel;
   logic [BSR-1:0] cap;
   logic [NO-1:0]  upd_o;
   logic [NB-1:0]  upd_bo;
   logic [NB-1:0]  upd_boe;
   logic [15:0]    part;

   assign cur     = bst_decode(q.ir);
   assign bsr_sel = (cur == in_extest) || (cur == in_sample);
   assign id_sel  = (cur == in_idcode) || (cur == in_usercode);
   assign part    = (cur == in_usercode) ? USER_PART : ID_PART;
   assign rise    = q.j2.tck & ~q.tck_prev;
   assign fall    = ~q.j2.tck & q.tck_prev;

   // -----------------------------------------------------------------
   // boundary cell map: inputs, outputs, then in/out/ctl per bidi pin
   // -----------------------------------------------------------------
   // output cells capture the driven value, control cells the driven enable
   assign cap[NI-1:0]     = q.in2;
   assign cap[NI+NO-1:NI] = q.out;
   assign upd_o           = q.bsr_up[NI+NO-1:NI];
   for (genvar k = 0; k < NB; k++) begin : g_bidi
      assign cap[NI+NO+3*k]     = q.bi2[k];
      assign cap[NI+NO+3*k+1]   = q.bo[k];
      assign cap[NI+NO+3*k+2]   = q.boe[k];
      assign upd_bo[k]          = q.bsr_up[NI+NO+3*k+1];
      assign upd_boe[k]         = q.bsr_up[NI+NO+3*k+2];
   end

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      d          = q;
      // two-flop synchronisers; only the second stage is read by logic
      d.j1       = jtag;
      d.j2       = q.j1;
      d.tck_prev = q.j2.tck;
      d.in1      = in_pin;
      d.in2      = q.in1;
      d.bi1      = bidi_i;
      d.bi2      = q.bi1;
      if (!q.j2.trst_n) begin
         d.st = st_tlr;
         d.ir = `BST_CODE_IDCODE;
      end else if (rise) begin
         d.st = bst_next(q.st, q.j2.tms);
         case (q.st)
            st_tlr: begin
               d.ir = `BST_CODE_IDCODE;
            end
            st_cap_ir: begin
               d.ir_sr  = `BST_IR_CAPTURE;
               d.ir_new = 1'b0;
            end
            st_sh_ir: begin
               d.ir_sr  = {q.j2.tdi, q.ir_sr[5:1]};
               d.ir_new = 1'b1;
            end
            st_upd_ir: begin
               d.ir = q.ir_new ? q.ir_sr : `BST_CODE_IDCODE;
            end
            st_cap_dr: begin
               d.byp   = 1'b0;
               d.id_sr = {ID_VER, part, ID_MAKER, `BST_ID_LSB};
               if (bsr_sel) begin
                  d.bsr_sr = cap;
               end
            end
            st_sh_dr: begin
               if (bsr_sel) begin
                  d.bsr_sr = {q.j2.tdi, q.bsr_sr[BSR-1:1]};
               end else if (id_sel) begin
                  d.id_sr = {q.j2.tdi, q.id_sr[31:1]};
               end else begin
                  d.byp = q.j2.tdi;
               end
            end
            st_upd_dr: begin
               if (bsr_sel) begin
                  d.bsr_up = q.bsr_sr;
               end
            end
            default: begin
            end
         endcase
      end
      // data out moves on the falling test clock so it is settled at the next rise
      if (fall) begin
         d.tdo_oe = (q.st == st_sh_dr) || (q.st == st_sh_ir);
         if (q.st == st_sh_ir) begin
            d.tdo = q.ir_sr[0];
         end else if (bsr_sel) begin
            d.tdo = q.bsr_sr[0];
         end else if (id_sel) begin
            d.tdo = q.id_sr[0];
         end else begin
            d.tdo = q.byp;
         end
      end
      if (q.st == st_tlr) begin
         d.tdo_oe = 1'b0;
      end
      // pin drive
      case (cur)
         in_extest, in_clamp: begin
            d.out    = upd_o;
            d.out_oe = '1;
            d.bo     = upd_bo;
            d.boe    = upd_boe;
         end
         in_highz: begin
            d.out    = core_out;
            d.out_oe = '0;
            d.bo     = core_bo;
            d.boe    = '0;
         end
         default: begin
            d.out    = core_out;
            d.out_oe = '1;
            d.bo     = core_bo;
            d.boe    = core_boe;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q        <= '0;
         q.st     <= st_tlr;
         q.ir     <= `BST_CODE_IDCODE;
         q.out_oe <= '1;
      end else begin
         q <= d;
      end
   end

   assign tdo     = q.tdo;
   assign tdo_oe  = q.tdo_oe;
   assign core_in = q.in2;
   assign core_bi = q.bi2;
   assign out_o   = q.out;
   assign out_oe  = q.out_oe;
   assign bidi_o  = q.bo;
   assign bidi_oe = q.boe;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence seq_upd_ir;
      rise && q.j2.trst_n && q.st == st_upd_ir;
   endsequence
   sequence seq_shift_byp;
      rise && q.j2.trst_n && q.st == st_sh_dr && !bsr_sel && !id_sel;
   endsequence
   sequence seq_cap_dr;
      rise && q.j2.trst_n && q.st == st_cap_dr;
   endsequence

   chk_trst_reset: assert property (!q.j2.trst_n |=> q.st == st_tlr && q.ir == `BST_CODE_IDCODE)
      else $error("test reset did not return controller to reset");
   chk_tlr_idcode: assert property (rise && q.j2.trst_n && q.st == st_tlr |=> cur == in_idcode)
      else $error("identification not selected after reset");
   chk_ir_default: assert property (seq_upd_ir and !q.ir_new |=> q.ir == `BST_CODE_IDCODE)
      else $error("default instruction not loaded");
   chk_ir_update: assert property (seq_upd_ir and q.ir_new |=> q.ir == $past(q.ir_sr))
      else $error("shifted instruction not loaded");
   chk_unused_bypass: assert property (!(q.ir inside {6'h00, 6'h01, 6'h02, 6'h05, 6'h24, 6'h25})
         |-> cur == in_bypass)
      else $error("unassigned code not bypass");
   chk_bypass_delay: assert property (seq_shift_byp |=> q.byp == $past(q.j2.tdi))
      else $error("bypass stage did not take data in");
   chk_clamp_hold: assert property (cur == in_clamp && $past(cur) == in_clamp ##1 cur == in_clamp
         |-> $stable(out_o) && out_oe == '1)
      else $error("clamped outputs moved");
   chk_extest_drive: assert property (cur == in_extest |=> out_o == $past(upd_o))
      else $error("extest outputs not from cells");
   chk_sample_core: assert property (cur == in_sample |=> out_o == $past(core_out) && bidi_oe == $past(core_boe))
      else $error("sample disturbed system outputs");
   chk_highz_float: assert property (cur == in_highz |=> out_oe == '0 && bidi_oe == '0)
      else $error("highz left an output driven");
   chk_id_capture: assert property (rise && q.j2.trst_n && q.st == st_cap_dr
         |=> q.id_sr[0] == 1'b1 && q.id_sr[31:28] == ID_VER && q.id_sr[11:1] == ID_MAKER)
      else $error("identification word wrong at capture");
   chk_tdo_float: assert property (fall && q.st != st_sh_dr && q.st != st_sh_ir |=> !tdo_oe)
      else $error("data out driven outside shift");

   // -----------------------------------------------------------------
   // data out enable, capture, update and pin drive checks
   // -----------------------------------------------------------------
   chk_tdo_shift: assert property (fall && (q.st == st_sh_dr || q.st == st_sh_ir) |=> tdo_oe)
      else $error("data out not driven during shift");
   chk_byp_capture: assert property (seq_cap_dr |=> !q.byp)
      else $error("bypass stage did not capture zero");
   chk_ir_capture: assert property (rise && q.j2.trst_n && q.st == st_cap_ir |=> q.ir_sr == `BST_IR_CAPTURE)
      else $error("instruction capture value wrong");
   chk_id_family: assert property (seq_cap_dr and cur == in_idcode
         |=> q.id_sr[27:12] == ID_PART)
      else $error("identification family field wrong");
   chk_user_part: assert property (seq_cap_dr and cur == in_usercode
         |=> q.id_sr[27:12] == USER_PART && q.id_sr[0] == `BST_ID_LSB)
      else $error("user code part field wrong");
   chk_bsr_update: assert property (rise && q.j2.trst_n && q.st == st_upd_dr && bsr_sel
         |=> q.bsr_up == $past(q.bsr_sr))
      else $error("boundary update cells not loaded");
   chk_clamp_bidi: assert property (cur == in_clamp
         |=> bidi_o == $past(upd_bo) && bidi_oe == $past(upd_boe) && out_o == $past(upd_o))
      else $error("clamp drive not from cells");
   chk_extest_bidi: assert property (cur == in_extest
         |=> bidi_o == $past(upd_bo) && bidi_oe == $past(upd_boe))
      else $error("extest bidirectional drive not from cells");
endmodule

// ---- sim/bst_tester.sv ----
// board tester model: drives the tap pins, samples serial data out
// assumes the tap samples its pins with a much faster clock
`timescale 1ns/100ps
module bst_tester import bst_pkg::*; (
   output bst_jtag_in_t jtag,
   input  wire logic    tdo,
   input  wire logic    tdo_oe
);
   // --------------------------------------------------------
   // one 125 ns test clock period, clock stands low between
   // --------------------------------------------------------
   initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

   task automatic step(input logic tms, input logic tdi, output logic so);
      jtag.tms = tms;
      jtag.tdi = tdi;
      #62.5;
      so = tdo_oe ? tdo : ~tdo;
      jtag.tck = 1'b1;
      #62.5;
      jtag.tck = 1'b0;
   endtask

   // scan n bits lsb first from run-test-idle back to run-test-idle
   task automatic scan(input bit ir, input int n, input logic [160:0] din, output logic [160:0] dout);
      logic s;
      dout = '0;
      step(1'b1, 1'b0, s);
      if (ir)
         step(1'b1, 1'b0, s);
      step(1'b0, 1'b0, s);
      step(n == 0, 1'b0, s);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], s);
         dout[i] = s;
      end
      step(1'b1, 1'b0, s);
      step(1'b0, 1'b0, s);
   endtask

   task automatic tap_reset();
      jtag.trst_n = 1'b0;
      #200;
      jtag.trst_n = 1'b1;
      #100;
   endtask
endmodule

// ---- sim/bst_tap_tb_top.sv ----
// self-checking bench for the boundary scan tap
// assumes bst_tester as the far side; pins randomised between scans
`timescale 1ns/100ps
module bst_tap_tb_top import bst_pkg::*;;
   localparam logic [3:0]  VER   = 4'h6;     // arbitrary
   localparam logic [15:0] PART  = 16'h3c21; // arbitrary
   localparam logic [15:0] UPART = 16'h3c22; // arbitrary
   localparam logic [10:0] MAKER = 11'h2b5;  // arbitrary
   logic         clk, rstn, tdo, tdo_oe, sbit;
   bst_jtag_in_t jtag;
   logic [39:0]  in_pin, core_in, core_out, out_o, out_oe, eo, eoe;
   logic [26:0]  core_bo, core_boe, core_bi, bidi_i, bidi_o, bidi_oe, ebo, eboe;
   logic [5:0]   code;
   logic [160:0] upd, cap, dout;
   int           n_errors = 0;
   int           check_count = 0;
   logic [5:0]   codes [9] = '{6'h01, 6'h00, 6'h02, 6'h05, 6'h24, 6'h25, 6'h3f, 6'h15, 6'h3e};

   bst_tap #(.ID_VER(VER), .ID_PART(PART), .USER_PART(UPART), .ID_MAKER(MAKER)) bst_tap_i (
      .clk(clk), .rstn(rstn), .jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe), .in_pin(in_pin),
      .core_in(core_in), .core_out(core_out), .out_o(out_o), .out_oe(out_oe), .core_bo(core_bo),
      .core_boe(core_boe), .core_bi(core_bi), .bidi_i(bidi_i), .bidi_o(bidi_o), .bidi_oe(bidi_oe));
   bst_tester bst_tester_i (.jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // --------------------------------------------------------
   // checking and model
   // --------------------------------------------------------
   task automatic chk(input string what, input logic [160:0] seen, input logic [160:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rnd();
      @(posedge clk);
      in_pin   <= 40'({$urandom, $urandom});
      core_out <= 40'({$urandom, $urandom});
      core_bo  <= 27'($urandom);
      core_boe <= 27'($urandom);
      bidi_i   <= 27'($urandom);
      @(posedge clk);
   endtask

   // expected pin drive and boundary capture for the current instruction
   task automatic model();
      eo = core_out;
      eoe = '1;
      ebo = core_bo;
      eboe = core_boe;
      if (code == 6'h00 || code == 6'h02) begin
         eo = upd[79:40];
         for (int k = 0; k < 27; k++) begin
            ebo[k] = upd[81+3*k];
            eboe[k] = upd[82+3*k];
         end
      end
      if (code == 6'h05) begin
         eoe = '0;
         eboe = '0;
      end
      cap[39:0] = in_pin;
      cap[79:40] = eo;
      for (int k = 0; k < 27; k++)
         cap[80+3*k +: 3] = {eboe[k], ebo[k], bidi_i[k]};
   endtask

   task automatic chk_pins();
      model();
      repeat (4) @(posedge clk);
      if (code != 6'h05)
         chk("out_o", out_o, eo);
      chk("out_oe", out_oe, eoe);
      chk("bidi_o", bidi_o, ebo);
      chk("bidi_oe", bidi_oe, eboe);
      chk("tdo_oe", tdo_oe, 1'b0);
      chk("core_in", core_in, in_pin);
      chk("core_bi", core_bi, bidi_i);
   endtask

   task automatic dr_test();
      logic [160:0] din, e, m;
      int           n;
      rnd();
      model();
      din = 161'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
      n = 8;
      e = {din[159:0], 1'b0};
      if (code == 6'h24 || code == 6'h25) begin
         n = 32;
         e = 161'({VER, (code == 6'h25) ? UPART : PART, MAKER, 1'b1});
      end
      if (code <= 6'h01) begin
         n = 161;
         e = cap;
      end
      m = (161'(1) << n) - 161'(1);
      bst_tester_i.scan(1'b0, n, din, dout);
      chk("dr out", dout & m, e & m);
      if (code <= 6'h01)
         upd = din;
      chk_pins();
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // --------------------------------------------------------
   // main sequence
   // --------------------------------------------------------
   initial begin
      void'($urandom(38));
      rstn = 1'b0;
      in_pin = '0;
      core_out = '0;
      core_bo = '0;
      core_boe = '0;
      bidi_i = '0;
      code = 6'h24;
      upd = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      chk("tdo_oe idle", tdo_oe, 1'b0);
      bst_tester_i.step(1'b0, 1'b0, sbit);
      dr_test();
      // sample/preload comes first so extest drives known cells
      foreach (codes[i]) begin
         rnd();
         bst_tester_i.scan(1'b1, 6, 161'(codes[i]), dout);
         chk("ir capture", dout[5:0], 6'h01);
         code = codes[i];
         chk_pins();
         dr_test();
      end
      bst_tester_i.scan(1'b1, 0, '0, dout);
      code = 6'h24;
      dr_test();
      bst_tester_i.scan(1'b1, 6, 161'(6'h3f), dout);
      bst_tester_i.tap_reset();
      bst_tester_i.step(1'b0, 1'b0, sbit);
      dr_test();
      summarize();
   end

   initial begin
      #400000;
      n_errors++;
      summarize();
   end
endmodule
